// ==== src/ftm_consts.vh ====
// Constants for the frequency trip monitor
`ifndef FTM_CONSTS_VH
`define FTM_CONSTS_VH

// Register byte offsets
`define FTM_A_CTRL 5'h00
`define FTM_A_TRIP 5'h04
`define FTM_A_CAPT 5'h08
`define FTM_A_STAT 5'h0c
`define FTM_A_FREQ 5'h10

// Control field positions
`define FTM_F_MODE 2:0
`define FTM_F_RESP 6:3
`define FTM_F_OFFS 10:7
`define FTM_F_HYST 14:11
`define FTM_B_SETUP 15
`define FTM_F_SEL 17:16
`define FTM_CTRL_RST 18'h00000

// Output modes
`define FTM_M_OVER 3'h0
`define FTM_M_OVER_L 3'h1
`define FTM_M_UNDER 3'h2
`define FTM_M_UNDER_L 3'h3
`define FTM_M_UNDER_I 3'h4
`define FTM_M_UNDER_IL 3'h5

// Trip frequency in units of 0.01 Hz
`define FTM_TRIP_RST 22'h0186a0
`define FTM_TRIP_MIN 22'h00000a
`define FTM_TRIP_MAX 22'h2625a0

// Timing: clock in Hz, times in their own units
`define FTM_CLK_HZ 32'h05f5e100
`define FTM_DEB_US 32'h000001f4
`define FTM_MAXP_MS 32'h00002710
`define FTM_BLINK_MS 32'h00000064
`define FTM_CHZ_PER_KHZ 56'h00000000186a0

`endif

// ==== src/ftm_top.v ====
// Frequency trip monitor: measurement, trip decision and register port
`include "ftm_consts.vh"

module ftm_top #(
  parameter [31:0] CYC_PER_MS = `FTM_CLK_HZ / 32'h000003e8,
  parameter [31:0] DEB_CYC = `FTM_DEB_US * (`FTM_CLK_HZ / 32'h000f4240),
  parameter [31:0] MAXP_CYC = `FTM_MAXP_MS * (`FTM_CLK_HZ / 32'h000003e8),
  parameter [31:0] BLINK_CYC = `FTM_BLINK_MS * (`FTM_CLK_HZ / 32'h000003e8)
) (
  input wire clk_sys, // System clock
  input wire rst, // Synchronous reset, active high
  input wire sens_pulse, // Sensor pulse stream
  input wire force_rel_n, // Force-release button, active low
  input wire latch_clr_n, // Latch-clear button, active low
  input wire [4:0] bus_addr, // Register byte address
  input wire [31:0] bus_wdata, // Write data
  input wire bus_wr, // Write strobe
  input wire bus_rd, // Read strobe
  output reg [31:0] bus_rdata, // Read data, cycle after strobe
  output reg relay_trip, // Relay drive, high when tripped
  output reg led_input, // Input activity indicator
  output reg led_trip // Trip state indicator
);

  localparam [1:0] ST_ARM = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;
  localparam [55:0] FREQ_K = {24'h000000, CYC_PER_MS} * `FTM_CHZ_PER_KHZ;

  function [13:0] resp_ms;
    input [3:0] s;
    begin
      case (s)
        4'h0: resp_ms = 14'h0005;
        4'h1: resp_ms = 14'h000a;
        4'h2: resp_ms = 14'h0014;
        4'h3: resp_ms = 14'h0032;
        4'h4: resp_ms = 14'h0064;
        4'h5: resp_ms = 14'h00c8;
        4'h6: resp_ms = 14'h01f4;
        4'h7: resp_ms = 14'h03e8;
        4'h8: resp_ms = 14'h07d0;
        default: resp_ms = 14'h2710;
      endcase
    end
  endfunction

  // Fraction of trip frequency, scaled by 2^16; step 0 disables
  function [15:0] pct;
    input [3:0] s;
    begin
      case (s)
        4'h0: pct = 16'h0000;
        4'h1: pct = 16'h00a4;
        4'h2: pct = 16'h0148;
        4'h3: pct = 16'h028f;
        4'h4: pct = 16'h051f;
        4'h5: pct = 16'h0ccd;
        4'h6: pct = 16'h199a;
        4'h7: pct = 16'h3333;
        4'h8: pct = 16'h4000;
        default: pct = 16'h5553;
      endcase
    end
  endfunction

  function [21:0] part;
    input [21:0] t;
    input [3:0] s;
    reg [37:0] p;
    begin
      p = t * pct(s);
      part = p[37:16];
    end
  endfunction

  function [21:0] clamp_trip;
    input [21:0] f;
    begin
      if (f < `FTM_TRIP_MIN)
        clamp_trip = `FTM_TRIP_MIN;
      else if (f > `FTM_TRIP_MAX)
        clamp_trip = `FTM_TRIP_MAX;
      else
        clamp_trip = f;
    end
  endfunction

  // Input synchronisers
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg pulse_d_reg;
  always @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      pulse_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {latch_clr_n, force_rel_n, sens_pulse};
      sync2_reg <= sync1_reg;
      pulse_d_reg <= sync2_reg[0];
    end
  end
  wire fall = pulse_d_reg & ~sync2_reg[0];

  // Button filters: level must hold for DEB_CYC cycles
  reg [1:0] btn_reg;
  reg [31:0] deb_reg [0:1];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_deb
      always @(posedge clk_sys) begin
        if (rst) begin
          btn_reg[gi] <= 1'b1;
          deb_reg[gi] <= 32'h00000000;
        end else if (sync2_reg[gi+1] == btn_reg[gi]) begin
          deb_reg[gi] <= 32'h00000000;
        end else if (deb_reg[gi] >= DEB_CYC - 32'h00000001) begin
          btn_reg[gi] <= sync2_reg[gi+1];
          deb_reg[gi] <= 32'h00000000;
        end else begin
          deb_reg[gi] <= deb_reg[gi] + 32'h00000001;
        end
      end
    end
  endgenerate
  wire force_act = ~btn_reg[0];
  wire clr_act = ~btn_reg[1];

  // Configuration, status and relay state registers
  reg [17:0] ctrl_reg;
  reg [21:0] trip_reg;
  reg cap_reg;
  reg [21:0] freq_reg;
  reg relay_reg;
  reg armed_reg;
  reg rel_reg;
  reg valid_reg;
  wire wr_ctrl = bus_wr & (bus_addr == `FTM_A_CTRL);
  wire wr_trip = bus_wr & (bus_addr == `FTM_A_TRIP);
  wire wr_capt = bus_wr & (bus_addr == `FTM_A_CAPT);
  wire [2:0] mode = ctrl_reg[`FTM_F_MODE];
  wire over = (mode == `FTM_M_OVER) | (mode == `FTM_M_OVER_L);
  wire latch = (mode == `FTM_M_OVER_L) | (mode == `FTM_M_UNDER_L) |
    (mode == `FTM_M_UNDER_IL);
  wire inhibit = (mode == `FTM_M_UNDER_I) | (mode == `FTM_M_UNDER_IL);
  wire setup = ctrl_reg[`FTM_B_SETUP];

  // Window length and give-up limit
  wire [45:0] win_full = resp_ms(ctrl_reg[`FTM_F_RESP]) * CYC_PER_MS;
  wire [31:0] win_cyc = win_full[31:0];
  wire [31:0] lim_cyc = win_cyc + MAXP_CYC;

  // Measurement: window opens on a falling edge, closes on the first
  // falling edge after the window time has passed
  reg [1:0] st_reg;
  reg [31:0] e_reg;
  reg [17:0] n_reg;
  reg eval_reg;
  reg [17:0] en_reg;
  reg [31:0] ee_reg;
  always @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= ST_ARM;
      e_reg <= 32'h00000000;
      n_reg <= 18'h00000;
      eval_reg <= 1'b0;
      en_reg <= 18'h00000;
      ee_reg <= 32'h00000001;
    end else begin
      eval_reg <= 1'b0;
      case (st_reg)
        ST_ARM: begin
          if (fall) begin
            st_reg <= ST_RUN;
            e_reg <= 32'h00000000;
            n_reg <= 18'h00000;
          end else if (e_reg >= lim_cyc) begin
            e_reg <= 32'h00000000;
            eval_reg <= 1'b1;
            en_reg <= 18'h00000;
            ee_reg <= 32'h00000001;
          end else begin
            e_reg <= e_reg + 32'h00000001;
          end
        end
        ST_RUN: begin
          if (fall && e_reg >= win_cyc - 32'h00000001) begin
            eval_reg <= 1'b1;
            en_reg <= n_reg + 18'h00001;
            ee_reg <= e_reg + 32'h00000001;
            e_reg <= 32'h00000000;
            n_reg <= 18'h00000;
          end else if (e_reg >= lim_cyc) begin
            st_reg <= ST_ARM;
            eval_reg <= 1'b1;
            en_reg <= 18'h00000;
            ee_reg <= 32'h00000001;
            e_reg <= 32'h00000000;
          end else begin
            e_reg <= e_reg + 32'h00000001;
            if (fall && n_reg != 18'h3ffff)
              n_reg <= n_reg + 18'h00001;
          end
        end
        default: st_reg <= ST_ARM;
      endcase
    end
  end

  // Restoring divider: count * clock * 100 / cycles = 0.01 Hz units
  reg [55:0] num_reg;
  reg [31:0] den_reg;
  reg [31:0] rem_reg;
  reg [5:0] dcnt_reg;
  reg busy_reg;
  reg done_reg;
  wire [32:0] rem_sh = {rem_reg, num_reg[55]};
  wire ge = rem_sh >= {1'b0, den_reg};
  wire [32:0] rem_sub = rem_sh - {1'b0, den_reg};
  always @(posedge clk_sys) begin
    if (rst) begin
      num_reg <= 56'h0;
      den_reg <= 32'h00000001;
      rem_reg <= 32'h00000000;
      dcnt_reg <= 6'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (eval_reg) begin
        num_reg <= en_reg * FREQ_K;
        den_reg <= ee_reg;
        rem_reg <= 32'h00000000;
        dcnt_reg <= 6'h38;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        num_reg <= {num_reg[54:0], ge};
        rem_reg <= ge ? rem_sub[31:0] : rem_sh[31:0];
        dcnt_reg <= dcnt_reg - 6'h01;
        if (dcnt_reg == 6'h01) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end
  wire [21:0] meas = (|num_reg[55:22]) ? 22'h3fffff : num_reg[21:0];

  // Trip and release points
  wire [21:0] offs = part(trip_reg, ctrl_reg[`FTM_F_OFFS]);
  wire [21:0] hyst = part(trip_reg, ctrl_reg[`FTM_F_HYST]);
  wire [22:0] p_up = {1'b0, trip_reg} + {1'b0, offs};
  wire [22:0] p_dn = (trip_reg > offs) ? {1'b0, trip_reg - offs} : 23'h0;
  wire [22:0] tp = over ? p_up : p_dn;
  wire [22:0] r_dn = (tp > {1'b0, hyst}) ? tp - {1'b0, hyst} : 23'h0;
  wire [22:0] rp = over ? r_dn : tp + {1'b0, hyst};
  wire [22:0] fm = {1'b0, meas};
  wire in_trip = over ? (fm > tp) : (fm < tp);
  wire in_rel = over ? (fm < rp) : (fm > rp);

  // Relay state
  always @(posedge clk_sys) begin
    if (rst) begin
      relay_reg <= 1'b0;
      armed_reg <= 1'b0;
      rel_reg <= 1'b0;
      valid_reg <= 1'b0;
      freq_reg <= 22'h000000;
    end else begin
      if (done_reg) begin
        freq_reg <= meas;
        rel_reg <= in_rel;
        valid_reg <= 1'b1;
      end
      if (wr_ctrl)
        armed_reg <= 1'b0;
      else if (done_reg && in_rel)
        armed_reg <= 1'b1;
      if (force_act) begin
        relay_reg <= 1'b0;
      end else if (done_reg && in_trip && (!inhibit || armed_reg)) begin
        relay_reg <= 1'b1;
      end else if (done_reg && in_rel && !latch) begin
        relay_reg <= 1'b0;
      end else if (latch && clr_act && rel_reg && !(done_reg && !in_rel)) begin
        relay_reg <= 1'b0;
      end
    end
  end

  // Registers written by software, capture of live frequency
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= `FTM_CTRL_RST;
      trip_reg <= `FTM_TRIP_RST;
      cap_reg <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= bus_wdata[17:0];
      if (wr_trip)
        trip_reg <= clamp_trip(bus_wdata[21:0]);
      else if (done_reg && cap_reg)
        trip_reg <= clamp_trip(meas);
      if (wr_capt && bus_wdata[0])
        cap_reg <= 1'b1;
      else if (done_reg)
        cap_reg <= 1'b0;
    end
  end

  // Set-up display: the activity LED blinks the selected field value
  reg [31:0] bl_reg;
  reg [4:0] ph_reg;
  reg [3:0] show;
  always @* begin
    case (ctrl_reg[`FTM_F_SEL])
      2'h0: show = {1'b0, ctrl_reg[`FTM_F_MODE]};
      2'h1: show = ctrl_reg[`FTM_F_RESP];
      2'h2: show = ctrl_reg[`FTM_F_OFFS];
      default: show = ctrl_reg[`FTM_F_HYST];
    endcase
  end
  wire [3:0] sel4 = {2'h0, ctrl_reg[`FTM_F_SEL]};

  always @(posedge clk_sys) begin
    if (rst) begin
      bl_reg <= 32'h00000000;
      ph_reg <= 5'h00;
      led_input <= 1'b0;
      led_trip <= 1'b0;
      relay_trip <= 1'b0;
    end else begin
      relay_trip <= relay_reg;
      if (bl_reg >= BLINK_CYC - 32'h00000001) begin
        bl_reg <= 32'h00000000;
        ph_reg <= ph_reg + 5'h01;
      end else begin
        bl_reg <= bl_reg + 32'h00000001;
      end
      if (setup) begin
        led_input <= ph_reg[0] & (ph_reg[4:1] < show);
        led_trip <= ph_reg[0] & (ph_reg[4:1] <= sel4);
      end else begin
        if (fall)
          led_input <= ~led_input;
        led_trip <= relay_reg;
      end
    end
  end

  // Register read port
  always @(posedge clk_sys) begin
    if (rst) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_rd) begin
      case (bus_addr)
        `FTM_A_CTRL: bus_rdata <= {14'h0000, ctrl_reg};
        `FTM_A_TRIP: bus_rdata <= {10'h000, trip_reg};
        `FTM_A_CAPT: bus_rdata <= {31'h00000000, cap_reg};
        `FTM_A_STAT: bus_rdata <= {27'h0000000, valid_reg, armed_reg, clr_act,
          force_act, relay_reg};
        `FTM_A_FREQ: bus_rdata <= {10'h000, freq_reg};
        default: bus_rdata <= 32'h00000000;
      endcase
    end else begin
      bus_rdata <= 32'h00000000;
    end
  end

endmodule // ftm_top

// ==== dv/ftm_chk.sv ====
// Port assertions for the frequency trip monitor
`include "ftm_consts.vh"
module ftm_chk #(
  parameter [31:0] DEB_CYC = 32'h8
) (
  input wire clk_sys, // Clock
  input wire rst, // Reset
  input wire sens_pulse, // Sensor
  input wire force_rel_n, // Force button
  input wire [4:0] bus_addr, // Address
  input wire [31:0] bus_wdata, // Write data
  input wire bus_wr, // Write
  input wire bus_rd, // Read
  input wire [31:0] bus_rdata, // Read data
  input wire relay_trip, // Relay
  input wire led_input, // Activity LED
  input wire led_trip // Trip LED
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] lo_cnt;
  logic [3:0] fall_age;
  logic sens_q;
  logic set_r;
  logic [2:0] hist;
  always @(posedge clk_sys) begin
    sens_q <= sens_pulse;
    hist <= {hist[1:0], set_r};
    if (rst) begin
      lo_cnt <= 32'h0;
      fall_age <= 4'hf;
      set_r <= 1'b0;
    end else begin
      lo_cnt <= force_rel_n ? 32'h0 : lo_cnt + {31'h0, lo_cnt != 32'hffff};
      fall_age <= (sens_q && !sens_pulse) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
      if (bus_wr && bus_addr == `FTM_A_CTRL)
        set_r <= bus_wdata[15];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  rst_quiet_a: assert property ($past(rst) |-> !relay_trip && !led_trip && !led_input)
    else $error("outputs active after reset");
  force_hold_a: assert property (lo_cnt > DEB_CYC + 32'h6 |-> !relay_trip)
    else $error("relay tripped under force");
  rd_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data without read");
  unmapped_a: assert property (bus_rd && (bus_addr[1:0] != 2'h0 || bus_addr > 5'h10)
    |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
  trip_range_a: assert property (bus_rd && bus_addr == `FTM_A_TRIP
    |=> bus_rdata >= 32'ha && bus_rdata <= 32'h2625a0)
    else $error("trip frequency out of range");
  freq_sat_a: assert property (bus_rd && bus_addr == `FTM_A_FREQ |=> bus_rdata <= 32'h3fffff)
    else $error("frequency wider than field");
  stat_relay_a: assert property (bus_rd && bus_addr == `FTM_A_STAT
    |=> bus_rdata[0] == relay_trip)
    else $error("status relay bit differs");
  led_relay_a: assert property (!set_r && hist == 3'h0 && $rose(relay_trip) |-> ##[0:1] led_trip)
    else $error("trip LED missed relay");
  led_act_a: assert property (!set_r && hist == 3'h0 && led_input != $past(led_input)
    |-> fall_age < 4'h8)
    else $error("activity LED without input edge");
endmodule // ftm_chk

// ==== dv/ftm_sensor.sv ====
// Sensor pulse source: square wave, held high by its pull-up when stopped
module ftm_sensor (
  input wire clk_sys, // Clock
  input wire [15:0] period, // Cycles per pulse, zero stops
  output logic sens_pulse // Pulse stream
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt = 16'h0;
  initial sens_pulse = 1'b1;
  always @(posedge clk_sys) begin
    cnt <= (period == 16'h0 || cnt >= period - 16'h1) ? 16'h0 : cnt + 16'h1;
    sens_pulse <= period == 16'h0 || cnt < (period >> 1);
  end
endmodule // ftm_sensor

// ==== dv/frequency_trip_monitor_test.sv ====
// Self-checking bench for the frequency trip monitor
`include "ftm_consts.vh"
module frequency_trip_monitor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic force_rel_n = 1'b1;
  logic latch_clr_n = 1'b1;
  logic [4:0] bus_addr = 5'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] period = 16'h0;
  wire [31:0] bus_rdata;
  wire sens_pulse, relay_trip, led_input, led_trip;
  logic [63:0] exp_q[$];
  logic [63:0] n;
  logic [31:0] v;
  logic pend = 1'b0;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 54;
  always #5 clk_sys = ~clk_sys;
  ftm_sensor ftm_sensor_inst (.clk_sys(clk_sys), .period(period), .sens_pulse(sens_pulse));
  ftm_top #(.CYC_PER_MS(32'h64), .DEB_CYC(32'h8), .MAXP_CYC(32'h7d0), .BLINK_CYC(32'h10))
    ftm_top_inst (.clk_sys(clk_sys), .rst(rst), .sens_pulse(sens_pulse),
    .force_rel_n(force_rel_n), .latch_clr_n(latch_clr_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .relay_trip(relay_trip), .led_input(led_input), .led_trip(led_trip));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back({m, e});
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Poll the relay under a bound, then confirm through the status word
  task automatic wait_rel(input logic want, input int c);
    for (int i = 0; i < c && relay_trip !== want; i++)
      @(posedge clk_sys);
    check({31'h0, led_trip}, {31'h0, want});
    rd(`FTM_A_STAT, 32'h1, {31'h0, want});
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (pend) begin
      n = exp_q.pop_front();
      check(bus_rdata & n[63:32], n[31:0]);
    end
    pend = bus_rd;
    if (cycles == 90000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    idle(8);
    rst <= 1'b0;
    idle(1);
    rd(`FTM_A_CTRL, 32'h3ffff, 32'h0);
    rd(`FTM_A_TRIP, 32'hffffffff, 32'h186a0);
    rd(`FTM_A_STAT, 32'h1, 32'h0);
    rd(5'h14, 32'hffffffff, 32'h0);
    wr(`FTM_A_TRIP, 32'h0);
    rd(`FTM_A_TRIP, 32'hffffffff, 32'ha);
    wr(`FTM_A_TRIP, 32'h3fffff);
    rd(`FTM_A_TRIP, 32'hffffffff, 32'h2625a0);
    v = 32'ha + ({$random(seed)} % 32'h262597);
    wr(`FTM_A_TRIP, v);
    rd(`FTM_A_TRIP, 32'hffffffff, v);
    for (int m = 0; m < 6; m++) begin
      v = ({$random(seed)} & 32'h7ff8) | m;
      wr(`FTM_A_CTRL, v);
      rd(`FTM_A_CTRL, 32'h3ffff, v);
    end
    wr(`FTM_A_TRIP, 32'h186a0);
    wr(`FTM_A_CTRL, 32'h0);
    period <= 16'h32;
    wait_rel(1'b1, 3000);
    rd(`FTM_A_FREQ, 32'h3fffff, 32'h30d40);
    period <= 16'hc8;
    wait_rel(1'b0, 3000);
    period <= 16'h32;
    wait_rel(1'b1, 3000);
    force_rel_n <= 1'b0;
    idle(30);
    rd(`FTM_A_STAT, 32'h3, 32'h2);
    idle(1500);
    rd(`FTM_A_STAT, 32'h3, 32'h2);
    force_rel_n <= 1'b1;
    wait_rel(1'b1, 3000);
    wr(`FTM_A_CAPT, 32'h1);
    idle(2000);
    rd(`FTM_A_TRIP, 32'hffffffff, 32'h30d40);
    rd(`FTM_A_CAPT, 32'h1, 32'h0);
    wr(`FTM_A_TRIP, 32'h186a0);
    wr(`FTM_A_CTRL, 32'h2);
    wait_rel(1'b0, 3000);
    period <= 16'h0;
    wait_rel(1'b1, 6000);
    rd(`FTM_A_FREQ, 32'h3fffff, 32'h0);
    wr(`FTM_A_CTRL, 32'h3);
    latch_clr_n <= 1'b0;
    idle(40);
    latch_clr_n <= 1'b1;
    idle(3000);
    rd(`FTM_A_STAT, 32'h1, 32'h1);
    period <= 16'h32;
    idle(3000);
    rd(`FTM_A_STAT, 32'h1, 32'h1);
    latch_clr_n <= 1'b0;
    wait_rel(1'b0, 100);
    latch_clr_n <= 1'b1;
    period <= 16'h61;
    idle(3000);
    wr(`FTM_A_CTRL, 32'h3280);
    idle(3000);
    rd(`FTM_A_STAT, 32'h1, 32'h0);
    period <= 16'h5a;
    wait_rel(1'b1, 3000);
    period <= 16'h66;
    idle(3000);
    rd(`FTM_A_STAT, 32'h1, 32'h1);
    period <= 16'h6e;
    wait_rel(1'b0, 3000);
    // Start-up inhibit: no underspeed trip until one release-region result
    wr(`FTM_A_CTRL, 32'h4);
    period <= 16'h0;
    idle(6000);
    rd(`FTM_A_STAT, 32'h9, 32'h0);
    period <= 16'h32;
    idle(3000);
    rd(`FTM_A_STAT, 32'h9, 32'h8);
    period <= 16'h0;
    wait_rel(1'b1, 6000);
    idle(3);
    stop_test;
  end
endmodule // frequency_trip_monitor_test
bind ftm_top ftm_chk #(.DEB_CYC(DEB_CYC)) ftm_chk_inst (.clk_sys(clk_sys), .rst(rst),
  .sens_pulse(sens_pulse), .force_rel_n(force_rel_n), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .relay_trip(relay_trip), .led_input(led_input), .led_trip(led_trip));
